// *** rtl/rrt_pkg.sv ***
// shared types and constants for the register and ram transfer unit
package rrt_pkg;

   // ==========================================================
   // widths
   localparam int NIB_W = 4;          // one core data nibble
   localparam int FILE_W = 2;         // file pointer width
   localparam int PORT_W = 3;         // port-control register width
   localparam int BYTE_W = 2 * NIB_W; // byte register width
   localparam int DP_W = FILE_W + NIB_W; // data_pointer width

   // ==========================================================
   // pointer step constants
   localparam logic [NIB_W-1:0] COL_ONE = 4'h1;  // step size
   localparam logic [NIB_W-1:0] COL_ZERO = 4'h0; // wrap after inc
   localparam logic [NIB_W-1:0] COL_TOP = 4'hF;  // wrap after dec

   // ==========================================================
   // reset values of the architectural registers
   localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
   localparam logic [FILE_W-1:0] RST_FILE = 2'h0;
   localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
   localparam logic [PORT_W-1:0] RST_PORT = 3'h0;

   // ==========================================================
   // decoded operations presented by the instruction decoder
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,         // any instruction outside this unit
      OP_AUX_TO_ACC = 4'h1,
      OP_ACC_TO_AUX = 4'h2,
      OP_COL_TO_ACC = 4'h3,
      OP_ACC_TO_COL = 4'h4,
      OP_PAIR_TO_BYTE = 4'h5,
      OP_BYTE_TO_PAIR = 4'h6,
      OP_ACC_TO_PORT = 4'h7,
      OP_POINTER_PAIR_LOAD = 4'h8,
      OP_COL_INC = 4'h9,
      OP_COL_DEC = 4'hA,
      OP_RAM_LOAD = 4'hB,
      OP_RAM_XCHG = 4'hC,
      OP_RAM_XCHG_DEC = 4'hD,
      OP_RAM_XCHG_INC = 4'hE,
      OP_ACC_IMM = 4'hF       // immediate accumulator load
   } rrt_op_t;

   // one instruction as handed to the unit
   typedef struct packed {
      rrt_op_t op;                 // decoded operation
      logic [FILE_W-1:0] imm_file; // x field or xor mask j
      logic [NIB_W-1:0] imm_nib;   // y field or immediate nibble
   } rrt_instr_t;

   // architectural registers as seen outside
   typedef struct packed {
      logic [NIB_W-1:0] acc;       // accumulator
      logic [NIB_W-1:0] aux;       // auxiliary register
      logic [FILE_W-1:0] file_ptr; // file pointer
      logic [NIB_W-1:0] col_ptr;   // column pointer
      logic [BYTE_W-1:0] byte_reg; // byte register
      logic [PORT_W-1:0] port_ctl; // port-control register
   } rrt_regs_t;

   localparam rrt_regs_t RST_REGS = '{
      acc: RST_NIB, aux: RST_NIB, file_ptr: RST_FILE,
      col_ptr: RST_NIB, byte_reg: RST_BYTE, port_ctl: RST_PORT};

   // sequencing states, gray along run -> skip -> run
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SKIP = 2'b01
   } rrt_state_t;

endpackage

// *** rtl/rrt_col_step.sv ***
// column pointer stepper with wrap detection
`timescale 1ns/100ps
module rrt_col_step (
   // pointer in
   input wire logic [rrt_pkg::NIB_W-1:0] col_in,
   input wire logic down_in,
   // stepped pointer out
   output logic [rrt_pkg::NIB_W-1:0] col_out,
   output logic wrap_out
);
   import rrt_pkg::*;

   // ==========================================================
   // step and wrap
   // one branch per direction: subtract when down_in is set, add otherwise
   always_comb begin
      if (down_in) begin
         col_out = col_in - COL_ONE;
         wrap_out = (col_out == COL_TOP);
      end else begin
         col_out = col_in + COL_ONE;
         wrap_out = (col_out == COL_ZERO);
      end
   end
endmodule // rrt_col_step

// *** rtl/rrt_ram.sv ***
// nibble-wide data ram with one write and one async read port
`timescale 1ns/100ps
module rrt_ram #(
   parameter int ADDR_W = rrt_pkg::DP_W
) (
   // clock
   input wire logic clk_sys_in,
   // write port
   input wire logic wr_en_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [rrt_pkg::NIB_W-1:0] wr_data_in,
   // read port
   output logic [rrt_pkg::NIB_W-1:0] rd_data_out
);
   import rrt_pkg::*;

   // storage, not reset: contents survive core reset like backup ram
   logic [NIB_W-1:0] mem_q [2**ADDR_W];

   // ==========================================================
   // read is combinational so an exchange completes in one cycle
   always_comb begin
      rd_data_out = mem_q[addr_in];
   end

   // ==========================================================
   // write
   always_ff @(posedge clk_sys_in) begin
      if (wr_en_in) begin
         mem_q[addr_in] <= wr_data_in;
      end
   end
endmodule // rrt_ram

// *** rtl/rrt_exec.sv ***
// execution unit for register, pointer and ram transfer instructions
//
// What this block does
// - aux to acc, carry untouched
// - acc to aux, carry untouched
// - column pointer to accumulator
// - accumulator to column pointer
// - aux high, acc low into byte
// - byte splits: high aux, low acc
// - accumulator into port-control register
// - pair load sets file and column
// - consecutive pair loads after first skipped
// - increment column, skip on zero
// - decrement column, skip on fifteen
// - ram word into acc, ram unchanged
// - exchange acc with pointed ram word
// - file pointer xor immediate after ram
// - exchange-decrement also steps column down, skips
// - exchange-increment also steps column up, skips
`timescale 1ns/100ps
module rrt_exec (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // instruction stream, one per instruction cycle
   input wire logic instr_valid_in,
   input wire rrt_pkg::rrt_instr_t instr_in,
   // architectural state
   output rrt_pkg::rrt_regs_t regs_out,
   output logic [rrt_pkg::DP_W-1:0] data_pointer_out,
   // sequencing status
   output logic skip_pend_out,
   output logic skipped_out
);
   import rrt_pkg::*;

   // ==========================================================
   // state record
   typedef struct packed {
      rrt_state_t fsm;   // run or skip-next
      rrt_regs_t regs;   // architectural registers
      logic skip_pend;   // registered copy of the skip state
      logic prev_pair;   // last consumed word was a pair load
      logic skipped;     // pulse: last word was consumed unexecuted
   } rrt_state_rec_t;

   localparam rrt_state_rec_t RST_STATE = '{
      fsm: ST_RUN, regs: RST_REGS, skip_pend: 1'b0,
      prev_pair: 1'b0, skipped: 1'b0};

   rrt_state_rec_t s_q; // current state
   rrt_state_rec_t s_d; // next state

   // ram side signals
   logic [DP_W-1:0] dp;              // current data pointer
   logic [NIB_W-1:0] ram_rd;         // pointed_ram_word
   logic ram_we;                     // write strobe for exchanges
   logic [NIB_W-1:0] ram_wd;         // value written back

   // stepper signals
   logic step_down;                  // direction of column step
   logic [NIB_W-1:0] col_stepped;    // stepped column pointer
   logic col_wrap;                   // stepped value wrapped

   // decode helpers
   logic is_pair;                    // current word is a pair load
   logic chain_skip;                 // pair load inside a chain

   // ==========================================================
   // helper functions

   // join file and column pointers into the ram address
   function automatic logic [DP_W-1:0] make_dp(
      input logic [FILE_W-1:0] f,
      input logic [NIB_W-1:0] c
   );
      make_dp = {f, c};
   endfunction

   // true for every ram access form
   function automatic logic is_ram_op(input rrt_op_t op);
      is_ram_op = (op == OP_RAM_LOAD) || (op == OP_RAM_XCHG) ||
                  (op == OP_RAM_XCHG_DEC) || (op == OP_RAM_XCHG_INC);
   endfunction

   // true for the forms that write the ram back
   function automatic logic is_xchg_op(input rrt_op_t op);
      is_xchg_op = (op == OP_RAM_XCHG) ||
                   (op == OP_RAM_XCHG_DEC) ||
                   (op == OP_RAM_XCHG_INC);
   endfunction

   // true for the forms that step the column downward
   function automatic logic is_down_op(input rrt_op_t op);
      is_down_op = (op == OP_COL_DEC) || (op == OP_RAM_XCHG_DEC);
   endfunction

   // ==========================================================
   // data pointer from the current register pair
   always_comb begin
      dp = make_dp(s_q.regs.file_ptr, s_q.regs.col_ptr);
   end

   // ==========================================================
   // data ram
   rrt_ram #(
      .ADDR_W(DP_W)
   ) u_ram (
      .clk_sys_in(clk_sys_in),
      .wr_en_in(ram_we),
      .addr_in(dp),
      .wr_data_in(ram_wd),
      .rd_data_out(ram_rd)
   );

   // ==========================================================
   // column stepper, shared by all stepping forms
   always_comb begin
      step_down = is_down_op(instr_in.op);
   end

   rrt_col_step u_step (
      .col_in(s_q.regs.col_ptr),
      .down_in(step_down),
      .col_out(col_stepped),
      .wrap_out(col_wrap)
   );

   // ==========================================================
   // pair-load chain detection
   // a chain is any run of pair loads, including ones that were
   // skipped for another reason, so the chain never restarts
   always_comb begin
      is_pair = (instr_in.op == OP_POINTER_PAIR_LOAD);
      chain_skip = is_pair && s_q.prev_pair;
   end

   // ==========================================================
   // ram write strobe: only exchanges that really execute
   // a skipped exchange must leave the ram alone
   always_comb begin
      ram_we = 1'b0;
      ram_wd = s_q.regs.acc;
      if (instr_valid_in && (s_q.fsm == ST_RUN) &&
          is_xchg_op(instr_in.op)) begin
         ram_we = 1'b1;
      end
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      s_d = s_q;
      s_d.skipped = 1'b0;
      if (instr_valid_in) begin
         // every consumed word updates the chain marker
         s_d.prev_pair = is_pair;
         case (s_q.fsm)
            ST_SKIP: begin
               // word fetched, cycle used, nothing changes
               s_d.fsm = ST_RUN;
               s_d.skip_pend = 1'b0;
               s_d.skipped = 1'b1;
            end
            ST_RUN: begin
               if (chain_skip) begin
                  // later pair loads of a chain do nothing
                  s_d.skipped = 1'b1;
               end else begin
                  case (instr_in.op)
                     OP_AUX_TO_ACC: begin
                        s_d.regs.acc = s_q.regs.aux;
                     end
                     OP_ACC_TO_AUX: begin
                        s_d.regs.aux = s_q.regs.acc;
                     end
                     OP_COL_TO_ACC: begin
                        s_d.regs.acc = s_q.regs.col_ptr;
                     end
                     OP_ACC_TO_COL: begin
                        s_d.regs.col_ptr = s_q.regs.acc;
                     end
                     OP_PAIR_TO_BYTE: begin
                        // aux is the upper nibble
                        s_d.regs.byte_reg =
                           {s_q.regs.aux, s_q.regs.acc};
                     end
                     OP_BYTE_TO_PAIR: begin
                        s_d.regs.aux =
                           s_q.regs.byte_reg[BYTE_W-1:NIB_W];
                        s_d.regs.acc =
                           s_q.regs.byte_reg[NIB_W-1:0];
                     end
                     OP_ACC_TO_PORT: begin
                        // register is narrower than a nibble
                        s_d.regs.port_ctl =
                           s_q.regs.acc[PORT_W-1:0];
                     end
                     OP_POINTER_PAIR_LOAD: begin
                        s_d.regs.file_ptr = instr_in.imm_file;
                        s_d.regs.col_ptr = instr_in.imm_nib;
                     end
                     OP_COL_INC: begin
                        s_d.regs.col_ptr = col_stepped;
                        if (col_wrap) begin
                           s_d.fsm = ST_SKIP;
                           s_d.skip_pend = 1'b1;
                        end
                     end
                     OP_COL_DEC: begin
                        s_d.regs.col_ptr = col_stepped;
                        if (col_wrap) begin
                           s_d.fsm = ST_SKIP;
                           s_d.skip_pend = 1'b1;
                        end
                     end
                     OP_RAM_LOAD: begin
                        // read only, no write strobe for this form
                        s_d.regs.acc = ram_rd;
                     end
                     OP_RAM_XCHG: begin
                        // ram side is written by the strobe above
                        s_d.regs.acc = ram_rd;
                     end
                     OP_RAM_XCHG_DEC: begin
                        s_d.regs.acc = ram_rd;
                        s_d.regs.col_ptr = col_stepped;
                        if (col_wrap) begin
                           s_d.fsm = ST_SKIP;
                           s_d.skip_pend = 1'b1;
                        end
                     end
                     OP_RAM_XCHG_INC: begin
                        s_d.regs.acc = ram_rd;
                        s_d.regs.col_ptr = col_stepped;
                        if (col_wrap) begin
                           s_d.fsm = ST_SKIP;
                           s_d.skip_pend = 1'b1;
                        end
                     end
                     OP_ACC_IMM: begin
                        // lets the core seed the accumulator
                        s_d.regs.acc = instr_in.imm_nib;
                     end
                     default: begin
                        // words for other units leave state alone
                        s_d.regs = s_q.regs;
                     end
                  endcase
                  // file pointer xor follows the access; the ram
                  // address was already formed from the old value
                  if (is_ram_op(instr_in.op)) begin
                     s_d.regs.file_ptr =
                        s_q.regs.file_ptr ^ instr_in.imm_file;
                  end
               end
            end
            default: begin
               // illegal encoding: return to a safe state
               s_d.fsm = ST_RUN;
               s_d.skip_pend = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // state register, synchronous reset
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs, all straight from the state register
   always_comb begin
      regs_out = s_q.regs;
      skip_pend_out = s_q.skip_pend;
      skipped_out = s_q.skipped;
   end

   // data pointer output is the flop pair itself
   always_comb begin
      data_pointer_out = make_dp(s_q.regs.file_ptr,
                                 s_q.regs.col_ptr);
   end

endmodule // rrt_exec

// *** tb/rrt_exec_assertions.sv ***
// concurrent checks on the ports of the register and ram transfer unit
`timescale 1ns/100ps
module rrt_exec_assertions (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // instruction stream
   input wire logic instr_valid_in,
   input wire rrt_pkg::rrt_instr_t instr_in,
   // observed state
   input wire rrt_pkg::rrt_regs_t regs_out,
   input wire logic [rrt_pkg::DP_W-1:0] data_pointer_out,
   input wire logic skip_pend_out,
   input wire logic skipped_out
);
   import rrt_pkg::*;
   // ==========================================================
   // helper logic
   logic chain_q; // last consumed word was a pair load
   logic go; // this word really executes
   logic [3:0] op; // shorthand for the decoded op
   assign op = instr_in.op;
   // skipped pair loads still continue a chain
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         chain_q <= 1'b0;
      end else if (instr_valid_in) begin
         chain_q <= (op == OP_POINTER_PAIR_LOAD);
      end
   end
   assign go = instr_valid_in && !skip_pend_out &&
      !(chain_q && op == OP_POINTER_PAIR_LOAD);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // transfers
   chk_aux_to_acc: assert property (go && op == OP_AUX_TO_ACC |=>
      regs_out.acc == $past(regs_out.aux) && $stable(regs_out.aux))
      else $error("aux to acc transfer wrong");
   chk_acc_to_aux: assert property (go && op == OP_ACC_TO_AUX |=>
      regs_out.aux == $past(regs_out.acc) && $stable(regs_out.acc))
      else $error("acc to aux transfer wrong");
   chk_col_to_acc: assert property (go && op == OP_COL_TO_ACC |=>
      regs_out.acc == $past(regs_out.col_ptr))
      else $error("column to acc transfer wrong");
   chk_acc_to_col: assert property (go && op == OP_ACC_TO_COL |=>
      regs_out.col_ptr == $past(regs_out.acc))
      else $error("acc to column transfer wrong");
   chk_byte_pack: assert property (go && op == OP_PAIR_TO_BYTE |=>
      regs_out.byte_reg == {$past(regs_out.aux), $past(regs_out.acc)})
      else $error("byte pack wrong");
   chk_byte_split: assert property (go && op == OP_BYTE_TO_PAIR |=>
      {regs_out.aux, regs_out.acc} == $past(regs_out.byte_reg))
      else $error("byte split wrong");
   chk_port_load: assert property (go && op == OP_ACC_TO_PORT |=>
      regs_out.port_ctl == $past(regs_out.acc[2:0]))
      else $error("port control load wrong");
   // ==========================================================
   // pointers and skipping
   chk_pair_load: assert property (go && op == OP_POINTER_PAIR_LOAD |=>
      regs_out.file_ptr == $past(instr_in.imm_file) &&
      regs_out.col_ptr == $past(instr_in.imm_nib))
      else $error("pair load wrong");
   chk_chain_skip: assert property (instr_valid_in && chain_q &&
      op == OP_POINTER_PAIR_LOAD |=> skipped_out && $stable(regs_out))
      else $error("chained pair load not skipped");
   chk_inc_wrap: assert property (go && op == OP_COL_INC |=>
      regs_out.col_ptr == $past(regs_out.col_ptr) + COL_ONE &&
      skip_pend_out == (regs_out.col_ptr == COL_ZERO))
      else $error("column increment wrong");
   chk_dec_wrap: assert property (go && op == OP_COL_DEC |=>
      regs_out.col_ptr == $past(regs_out.col_ptr) - COL_ONE &&
      skip_pend_out == (regs_out.col_ptr == COL_TOP))
      else $error("column decrement wrong");
   chk_ram_xor: assert property (go && op inside {OP_RAM_LOAD,
      OP_RAM_XCHG, OP_RAM_XCHG_DEC, OP_RAM_XCHG_INC} |=>
      regs_out.file_ptr == ($past(regs_out.file_ptr) ^
      $past(instr_in.imm_file)))
      else $error("file pointer xor wrong");
   chk_dp_join: assert property (
      data_pointer_out == {regs_out.file_ptr, regs_out.col_ptr})
      else $error("data pointer not file and column");
   chk_skip_quiet: assert property (instr_valid_in && skip_pend_out |=>
      skipped_out && !skip_pend_out ##0 $stable(regs_out))
      else $error("skipped word had an effect");
endmodule // rrt_exec_assertions

// *** tb/tb_rrt_exec.sv ***
// self-checking bench for the register and ram transfer unit
`timescale 1ns/100ps
module tb_rrt_exec;
   import rrt_pkg::*;
   // ==========================================================
   // stimulus and observation
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic instr_valid_in = 1'b0;
   rrt_instr_t instr_in = '0;
   rrt_regs_t regs_out;
   logic [DP_W-1:0] data_pointer_out;
   logic skip_pend_out;
   logic skipped_out;
   int errors = 0;
   int compares = 0;
   rrt_exec u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .instr_valid_in(instr_valid_in), .instr_in(instr_in),
      .regs_out(regs_out), .data_pointer_out(data_pointer_out),
      .skip_pend_out(skip_pend_out), .skipped_out(skipped_out));
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // ==========================================================
   // shared tasks
   task chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one word per cycle; the #1 lets the edge's updates land
   task step(input rrt_op_t op, input logic [1:0] f, input logic [3:0] n);
      instr_valid_in <= 1'b1;
      instr_in <= '{op, f, n};
      @(posedge clk_sys_in);
      #1;
   endtask
   task idle;
      instr_valid_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
   endtask
   task final_report;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task t_regs;
      step(OP_ACC_IMM, 2'h0, 4'h5);
      step(OP_ACC_TO_AUX, 2'h0, 4'h0);
      chk("aux", regs_out.aux, 4'h5);
      step(OP_ACC_IMM, 2'h0, 4'hA);
      step(OP_AUX_TO_ACC, 2'h0, 4'h0);
      chk("acc", regs_out.acc, 4'h5);
      step(OP_ACC_IMM, 2'h0, 4'hC);
      step(OP_ACC_TO_COL, 2'h0, 4'h0);
      chk("col", regs_out.col_ptr, 4'hC);
      step(OP_ACC_IMM, 2'h0, 4'h3);
      step(OP_COL_TO_ACC, 2'h0, 4'h0);
      chk("acc", regs_out.acc, 4'hC);
      step(OP_PAIR_TO_BYTE, 2'h0, 4'h0);
      chk("byte", regs_out.byte_reg, 8'h5C);
      step(OP_ACC_TO_AUX, 2'h0, 4'h0);
      step(OP_ACC_IMM, 2'h0, 4'h1);
      step(OP_BYTE_TO_PAIR, 2'h0, 4'h0);
      chk("aux_acc", {regs_out.aux, regs_out.acc}, 8'h5C);
      step(OP_ACC_TO_PORT, 2'h0, 4'h0);
      chk("port", regs_out.port_ctl, 3'h4);
      $display("t_regs done");
   endtask
   // chain of pair loads, idle inside it, broken by another op
   task t_pair;
      step(OP_POINTER_PAIR_LOAD, 2'h1, 4'h5);
      chk("dp", data_pointer_out, 6'h15);
      step(OP_POINTER_PAIR_LOAD, 2'h2, 4'h3);
      chk("skipped", skipped_out, 1'b1);
      chk("dp", data_pointer_out, 6'h15);
      idle();
      step(OP_POINTER_PAIR_LOAD, 2'h3, 4'h7);
      chk("dp", data_pointer_out, 6'h15);
      step(OP_NONE, 2'h0, 4'h0);
      step(OP_POINTER_PAIR_LOAD, 2'h2, 4'h3);
      chk("dp", data_pointer_out, 6'h23);
      $display("t_pair done");
   endtask
   task t_step;
      step(OP_NONE, 2'h0, 4'h0);
      step(OP_POINTER_PAIR_LOAD, 2'h0, 4'hE);
      step(OP_ACC_IMM, 2'h0, 4'h2);
      step(OP_COL_INC, 2'h0, 4'h0);
      chk("col_pend", {regs_out.col_ptr, skip_pend_out}, 5'h1E);
      step(OP_COL_INC, 2'h0, 4'h0);
      chk("col_pend", {regs_out.col_ptr, skip_pend_out}, 5'h01);
      step(OP_ACC_IMM, 2'h0, 4'h7);
      chk("acc_skip", {regs_out.acc, skipped_out}, 5'h05);
      step(OP_COL_DEC, 2'h0, 4'h0);
      chk("col_pend", {regs_out.col_ptr, skip_pend_out}, 5'h1F);
      step(OP_POINTER_PAIR_LOAD, 2'h1, 4'h1);
      chk("dp", data_pointer_out, 6'h0F);
      step(OP_COL_DEC, 2'h0, 4'h0);
      chk("col_pend", {regs_out.col_ptr, skip_pend_out}, 5'h1C);
      $display("t_step done");
   endtask
   // ram words are not reset, so each is written before a value read from it is checked
   task t_ram;
      step(OP_POINTER_PAIR_LOAD, 2'h0, 4'h4);
      step(OP_ACC_IMM, 2'h0, 4'h6);
      step(OP_RAM_XCHG, 2'h1, 4'h0);
      chk("file", regs_out.file_ptr, 2'h1);
      step(OP_ACC_IMM, 2'h0, 4'h9);
      step(OP_RAM_XCHG, 2'h1, 4'h0);
      chk("file", regs_out.file_ptr, 2'h0);
      step(OP_RAM_LOAD, 2'h3, 4'h0);
      chk("acc_file", {regs_out.acc, regs_out.file_ptr}, 6'h1B);
      step(OP_POINTER_PAIR_LOAD, 2'h0, 4'h4);
      step(OP_RAM_LOAD, 2'h0, 4'h0);
      chk("acc", regs_out.acc, 4'h6);
      step(OP_POINTER_PAIR_LOAD, 2'h1, 4'h4);
      step(OP_ACC_IMM, 2'h0, 4'hB);
      step(OP_RAM_XCHG_DEC, 2'h1, 4'h0);
      chk("acc", regs_out.acc, 4'h9);
      chk("dp_pend", {data_pointer_out, skip_pend_out}, 7'h06);
      step(OP_POINTER_PAIR_LOAD, 2'h1, 4'h4);
      step(OP_RAM_LOAD, 2'h0, 4'h0);
      chk("acc", regs_out.acc, 4'hB);
      // seed the word first so the skipped cycle sees no unknown acc
      step(OP_POINTER_PAIR_LOAD, 2'h0, 4'hF);
      step(OP_ACC_IMM, 2'h0, 4'h5);
      step(OP_RAM_XCHG, 2'h0, 4'h0);
      step(OP_ACC_IMM, 2'h0, 4'h3);
      step(OP_RAM_XCHG_INC, 2'h2, 4'h0);
      chk("dp_pend", {data_pointer_out, skip_pend_out}, 7'h41);
      chk("acc", regs_out.acc, 4'h5);
      step(OP_ACC_IMM, 2'h0, 4'h8);
      chk("skipped", skipped_out, 1'b1);
      step(OP_POINTER_PAIR_LOAD, 2'h0, 4'h0);
      step(OP_ACC_IMM, 2'h0, 4'h4);
      step(OP_RAM_XCHG, 2'h0, 4'h0);
      step(OP_ACC_IMM, 2'h0, 4'h1);
      step(OP_RAM_XCHG_DEC, 2'h0, 4'h0);
      chk("dp_pend", {data_pointer_out, skip_pend_out}, 7'h1F);
      chk("acc", regs_out.acc, 4'h4);
      step(OP_NONE, 2'h0, 4'h0);
      step(OP_RAM_LOAD, 2'h0, 4'h0);
      chk("acc", regs_out.acc, 4'h3);
      $display("t_ram done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      #1;
      chk("regs", regs_out, RST_REGS);
      t_regs();
      t_pair();
      t_step();
      t_ram();
      idle();
      final_report();
   end
   // whole run is about 60 cycles; 2000 means a hang
   initial begin
      #(4 * 2000);
      errors++;
      final_report();
   end
endmodule // tb_rrt_exec
bind rrt_exec rrt_exec_assertions u_chk (.clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
   .instr_in(instr_in), .regs_out(regs_out),
   .data_pointer_out(data_pointer_out), .skip_pend_out(skip_pend_out),
   .skipped_out(skipped_out));
